// >>> rtl/sssp_dev.sv
// Serial port in synchronous slave mode, clocked by the far shift clock
//
// Notes on behaviour
// - Slave mode whenever clock source bit clear
// - Master drives shift clock; port never drives it
// - First word loads at once, second waits held
// - Move held word, then raise transmit flag
// - Transmit flag with its enable wakes chip
// - Software sets sync, enable; clears receive enables
// - Ninth bit loaded before data word write
// - Holding write with transmit enabled starts sending
// - Single receive enable ignored in slave mode
// - Continuous receive works in any low-power state
// - Complete word moves to receive data register
// - Receive flag with its enable wakes chip
// - Receive flag set; interrupt only when enabled
// - Software reads status before received data
// - Clearing continuous receive clears error
// - Global and peripheral enables gate interrupts
// - Software sets sync, enable, nine-bit receive
// - Sample data on shift clock falling edge
// - Continuous receive repeats until bit cleared
//
// The register offsets and the plain read and write strobe interface to the registers were decided locally.
`include "sssp_regs.svh"
module sssp_dev import sssp_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  sssp_link_if.dev link,
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic wake_out,
  output logic irq_out
);
  sssp_dev_t c, n;
  logic [1:0] pins_s;
  logic ck_s, data_s;
  logic active, tx_on, rx_on, rise, fall;

  // The shift clock is only sampled, never driven from here
  sssp_sync #(.W(2)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .d_in({link.shift_clock, link.serial_data}),
    .q_out(pins_s)
  );

  assign ck_s = pins_s[1];
  assign data_s = pins_s[0];
  assign rise = ck_s & ~c.ck_d;
  assign fall = ~ck_s & c.ck_d;
  // Master mode is not built, so a set clock source bit idles the port
  assign active = c.port_en & c.sync_mode & ~c.clk_src;
  // Receive wins the shared line; single receive plays no part
  assign rx_on = active & c.cont_en;
  assign tx_on = active & c.tx_en & ~c.cont_en;

  always_comb begin
    logic [8:0] rtmp;
    logic load;
    rtmp = c.rx_shift;
    load = 1'b0;
    n = c;
    n.ck_d = ck_s;

    // Reads first, so that a flag set below in the same cycle survives
    if (reg_rd_in) begin
      n.rdata = 8'h00;
      case (reg_addr_in)
        `SSSP_A_RXCTL: begin
          n.rdata[`SSSP_RC_PORT_EN] = c.port_en;
          n.rdata[`SSSP_RC_NINE] = c.rx_nine;
          n.rdata[`SSSP_RC_SINGLE] = c.single_en;
          n.rdata[`SSSP_RC_CONT] = c.cont_en;
          n.rdata[`SSSP_RC_OVERRUN] = c.overrun;
          n.rdata[`SSSP_RC_NINTH] = c.rx_ninth;
        end
        `SSSP_A_TXCTL: begin
          n.rdata[`SSSP_TC_CLK_SRC] = c.clk_src;
          n.rdata[`SSSP_TC_NINE] = c.tx_nine;
          n.rdata[`SSSP_TC_EN] = c.tx_en;
          n.rdata[`SSSP_TC_SYNC] = c.sync_mode;
          n.rdata[`SSSP_TC_EMPTY] = (c.tx_st == SSSP_TX_IDLE);
          n.rdata[`SSSP_TC_NINTH] = c.tx_ninth;
        end
        `SSSP_A_BAUDCTL: begin
          n.rdata = c.baud_ctl;
          n.rdata[`SSSP_BC_RX_IDLE] = (c.rx_bit == 4'h0);
        end
        `SSSP_A_DIVHI: n.rdata = c.div_hi;
        `SSSP_A_DIVLO: n.rdata = c.div_lo;
        `SSSP_A_RXDATA: begin
          n.rdata = c.rx_data;
          n.rx_flag = 1'b0;
        end
        `SSSP_A_INTCTL: begin
          n.rdata[`SSSP_IC_GLOBAL] = c.glb_ie;
          n.rdata[`SSSP_IC_PERIPH] = c.per_ie;
          n.rdata[`SSSP_IC_RX_FLAG] = c.rx_flag;
          n.rdata[`SSSP_IC_TX_FLAG] = ~c.hold_full;
          n.rdata[`SSSP_IC_TX_EN] = c.tx_ie;
          n.rdata[`SSSP_IC_RX_EN] = c.rx_ie;
        end
        default: n.rdata = 8'h00;
      endcase
    end

    // Transmit: data changes on the rising shift clock edge
    case (c.tx_st)
      SSSP_TX_IDLE: begin
        load = tx_on & c.hold_full;
      end
      SSSP_TX_SHIFT: begin
        if (!tx_on) begin
          n.tx_st = SSSP_TX_IDLE;
        end else if (rise) begin
          n.dout = c.tx_shift[c.tx_bit];
        end else if (fall) begin
          n.tx_bit = c.tx_bit + 4'h1;
          if (n.tx_bit == sssp_word_bits(c.tx_nine)) begin
            n.tx_st = SSSP_TX_IDLE;
            load = c.hold_full;
          end
        end
      end
      default: n.tx_st = SSSP_TX_IDLE;
    endcase
    if (load) begin
      // Emptying the holding register is what raises the transmit flag
      n.tx_shift = {c.tx_ninth, c.tx_hold};
      n.hold_full = 1'b0;
      n.tx_bit = 4'h0;
      n.tx_st = SSSP_TX_SHIFT;
    end
    n.doe = tx_on;

    // Receive: keeps running word after word while enabled and no overrun is set
    if (!rx_on) begin
      n.rx_bit = 4'h0;
    end else if (fall && !c.overrun) begin
      rtmp[c.rx_bit] = data_s;
      n.rx_shift = rtmp;
      n.rx_bit = c.rx_bit + 4'h1;
      if (n.rx_bit == sssp_word_bits(c.rx_nine)) begin
        n.rx_bit = 4'h0;
        // An unread word is kept; the new one is lost and flagged
        if (c.rx_flag && n.rx_flag) begin
          n.overrun = 1'b1;
        end else begin
          n.rx_data = rtmp[7:0];
          n.rx_ninth = c.rx_nine & rtmp[8];
          n.rx_flag = 1'b1;
        end
      end
    end

    // Writes last: a holding write in a load cycle queues behind it
    if (reg_wr_in) begin
      case (reg_addr_in)
        `SSSP_A_RXCTL: begin
          n.port_en = reg_wdata_in[`SSSP_RC_PORT_EN];
          n.rx_nine = reg_wdata_in[`SSSP_RC_NINE];
          n.single_en = reg_wdata_in[`SSSP_RC_SINGLE];
          n.cont_en = reg_wdata_in[`SSSP_RC_CONT];
          if (!reg_wdata_in[`SSSP_RC_CONT]) begin
            n.overrun = 1'b0;
            n.rx_bit = 4'h0;
          end
        end
        `SSSP_A_TXHOLD: begin
          n.tx_hold = reg_wdata_in;
          n.hold_full = 1'b1;
        end
        `SSSP_A_TXCTL: begin
          n.clk_src = reg_wdata_in[`SSSP_TC_CLK_SRC];
          n.tx_nine = reg_wdata_in[`SSSP_TC_NINE];
          n.tx_en = reg_wdata_in[`SSSP_TC_EN];
          n.sync_mode = reg_wdata_in[`SSSP_TC_SYNC];
          n.tx_ninth = reg_wdata_in[`SSSP_TC_NINTH];
        end
        `SSSP_A_BAUDCTL: n.baud_ctl = reg_wdata_in;
        `SSSP_A_DIVHI: n.div_hi = reg_wdata_in;
        `SSSP_A_DIVLO: n.div_lo = reg_wdata_in;
        `SSSP_A_INTCTL: begin
          n.glb_ie = reg_wdata_in[`SSSP_IC_GLOBAL];
          n.per_ie = reg_wdata_in[`SSSP_IC_PERIPH];
          n.tx_ie = reg_wdata_in[`SSSP_IC_TX_EN];
          n.rx_ie = reg_wdata_in[`SSSP_IC_RX_EN];
        end
        default: n.rdata = n.rdata;
      endcase
    end

    // Wake needs only the source enable; the vector also needs the
    // global and peripheral enables
    n.wake = (~n.hold_full & n.tx_ie)
             | (n.rx_flag & n.rx_ie);
    n.irq = n.wake & n.glb_ie & n.per_ie;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      c <= '0;
    end else begin
      c <= n;
    end
  end

  assign link.dev_data_out = c.dout;
  assign link.dev_data_oe = c.doe;
  assign reg_rdata_out = c.rdata;
  assign wake_out = c.wake;
  assign irq_out = c.irq;
endmodule : sssp_dev

// >>> rtl/sssp_regs.svh
// Register map, field positions and timing constants of the serial port
`ifndef SSSP_REGS_SVH
`define SSSP_REGS_SVH
// Device register indices
`define SSSP_A_RXCTL 3'h0
`define SSSP_A_TXHOLD 3'h1
`define SSSP_A_TXCTL 3'h2
`define SSSP_A_BAUDCTL 3'h3
`define SSSP_A_DIVHI 3'h4
`define SSSP_A_DIVLO 3'h5
`define SSSP_A_RXDATA 3'h6
`define SSSP_A_INTCTL 3'h7
// receive_status_control fields
`define SSSP_RC_PORT_EN 7
`define SSSP_RC_NINE 6
`define SSSP_RC_SINGLE 5
`define SSSP_RC_CONT 4
`define SSSP_RC_OVERRUN 1
`define SSSP_RC_NINTH 0
// transmit_status_control fields
`define SSSP_TC_CLK_SRC 7
`define SSSP_TC_NINE 6
`define SSSP_TC_EN 5
`define SSSP_TC_SYNC 4
`define SSSP_TC_EMPTY 1
`define SSSP_TC_NINTH 0
// baud_control receiver idle field
`define SSSP_BC_RX_IDLE 6
// interrupt_control_register fields
`define SSSP_IC_GLOBAL 7
`define SSSP_IC_PERIPH 6
`define SSSP_IC_RX_FLAG 3
`define SSSP_IC_TX_FLAG 2
`define SSSP_IC_TX_EN 1
`define SSSP_IC_RX_EN 0
// Word lengths
`define SSSP_BITS_8 4'h8
`define SSSP_BITS_9 4'h9
// Controller: half period of the shift clock in system clocks
`define SSSP_HALF_DIV 8'h08
// Controller AXI4-Lite byte offsets and fields
`define SSSP_M_CTRL 4'h0
`define SSSP_M_DATA 4'h4
`define SSSP_M_STAT 4'h8
`define SSSP_M_RXD 4'hc
`define SSSP_M_SEND 0
`define SSSP_M_NINE 1
`define SSSP_M_BUSY 0
`define SSSP_M_DONE 1
`define SSSP_RESP_OK 2'h0
`define SSSP_RESP_ERR 2'h2
`endif

// >>> rtl/sssp_pkg.sv
// Types shared by both ends of the serial port
`include "sssp_regs.svh"
package sssp_pkg;
  typedef enum logic [1:0] {
    SSSP_TX_IDLE = 2'h0,
    SSSP_TX_SHIFT = 2'h1
  } sssp_tx_st_t;

  typedef enum logic [1:0] {
    SSSP_M_IDLE = 2'h0,
    SSSP_M_HIGH = 2'h1,
    SSSP_M_LOW = 2'h3
  } sssp_m_st_t;

  typedef struct packed {
    logic port_en, rx_nine, single_en, cont_en, overrun, rx_ninth;
    logic [7:0] rx_data;
    logic rx_flag;
    logic clk_src, tx_nine, tx_en, sync_mode, tx_ninth;
    logic [7:0] tx_hold;
    logic hold_full;
    sssp_tx_st_t tx_st;
    logic [8:0] tx_shift;
    logic [3:0] tx_bit;
    logic [8:0] rx_shift;
    logic [3:0] rx_bit;
    logic [7:0] baud_ctl, div_hi, div_lo;
    logic glb_ie, per_ie, tx_ie, rx_ie;
    logic ck_d, dout, doe;
    logic [7:0] rdata;
    logic wake, irq;
  } sssp_dev_t;

  typedef struct packed {
    logic send, nine, busy, done;
    sssp_m_st_t st;
    logic [8:0] tx, rx;
    logic [3:0] bitn;
    logic [7:0] cnt;
    logic ck, dout, doe;
    logic awr, wr, awg, wg;
    logic [3:0] wa;
    logic [8:0] wd;
    logic wl;
    logic [1:0] bresp;
    logic bv, arr, rv;
    logic [31:0] rd;
    logic [1:0] rresp;
  } sssp_mst_t;

  function automatic logic [3:0] sssp_word_bits(input logic nine);
    return nine ? `SSSP_BITS_9 : `SSSP_BITS_8;
  endfunction : sssp_word_bits
endpackage : sssp_pkg

// >>> rtl/sssp_link_if.sv
// Shift clock and shared data line between controller and port
interface sssp_link_if;
  logic shift_clock;
  logic dev_data_out, dev_data_oe;
  logic mst_data_out, mst_data_oe;
  logic serial_data;

  // Line idles high when nobody drives it
  assign serial_data = dev_data_oe ? dev_data_out :
                       mst_data_oe ? mst_data_out : 1'b1;

  modport dev (input shift_clock, input serial_data,
               output dev_data_out, output dev_data_oe);
  modport mst (output shift_clock, output mst_data_out,
               output mst_data_oe, input serial_data);
endinterface : sssp_link_if

// >>> rtl/sssp_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain
module sssp_sync #(
  parameter int W = 2
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1, s2;
  } sssp_sync_st_t;

  sssp_sync_st_t c, n;

  always_comb begin
    n = c;
    n.s1 = d_in;
    n.s2 = c.s1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      c <= '0;
    end else begin
      c <= n;
    end
  end

  assign q_out = c.s2;
endmodule : sssp_sync

// >>> rtl/sssp_mst.sv
// Controller end: makes the shift clock, sends or collects one word
`include "sssp_regs.svh"
module sssp_mst import sssp_pkg::*; #(
  parameter logic [7:0] HALF_DIV = `SSSP_HALF_DIV
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  sssp_link_if.mst link,
  input wire logic [3:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [3:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in
);
  sssp_mst_t c, n;
  logic data_s;

  sssp_sync #(.W(1)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .d_in(link.serial_data),
    .q_out(data_s)
  );

  always_comb begin
    n = c;
    // Shift clock: high half, then low half, per bit
    case (c.st)
      SSSP_M_IDLE: n.cnt = 8'h00;
      SSSP_M_HIGH: begin
        if (c.cnt == HALF_DIV - 8'h01) begin
          n.cnt = 8'h00;
          n.ck = 1'b0;
          n.st = SSSP_M_LOW;
          n.rx[c.bitn] = data_s;
        end else begin
          n.cnt = c.cnt + 8'h01;
        end
      end
      SSSP_M_LOW: begin
        if (c.cnt == HALF_DIV - 8'h01) begin
          n.cnt = 8'h00;
          n.bitn = c.bitn + 4'h1;
          if (n.bitn == sssp_word_bits(c.nine)) begin
            n.st = SSSP_M_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
            n.doe = 1'b0;
          end else begin
            n.ck = 1'b1;
            n.st = SSSP_M_HIGH;
            n.dout = c.tx[n.bitn];
          end
        end else begin
          n.cnt = c.cnt + 8'h01;
        end
      end
      default: n.st = SSSP_M_IDLE;
    endcase

    // AXI4-Lite write: address and data in either order
    if (awvalid_in && c.awr) begin
      n.awg = 1'b1;
      n.wa = awaddr_in;
    end
    if (wvalid_in && c.wr) begin
      n.wg = 1'b1;
      n.wd = wdata_in[8:0];
      n.wl = wstrb_in[0];
    end
    if (c.bv && bready_in) begin
      n.bv = 1'b0;
    end
    if (c.awg && c.wg && !c.bv) begin
      n.awg = 1'b0;
      n.wg = 1'b0;
      n.bv = 1'b1;
      n.bresp = `SSSP_RESP_OK;
      case (c.wa)
        `SSSP_M_CTRL: begin
          if (c.wl) begin
            n.send = c.wd[`SSSP_M_SEND];
            n.nine = c.wd[`SSSP_M_NINE];
          end
        end
        `SSSP_M_DATA: begin
          // A start while a frame runs is dropped, not queued
          if (c.wl && !c.busy) begin
            n.tx = c.wd;
            n.rx = 9'h000;
            n.bitn = 4'h0;
            n.cnt = 8'h00;
            n.busy = 1'b1;
            n.done = 1'b0;
            n.st = SSSP_M_HIGH;
            n.ck = 1'b1;
            n.dout = c.wd[0];
            n.doe = c.send;
          end
        end
        `SSSP_M_STAT, `SSSP_M_RXD: n.bresp = `SSSP_RESP_OK;
        default: n.bresp = `SSSP_RESP_ERR;
      endcase
    end
    n.awr = ~n.awg & ~n.bv;
    n.wr = ~n.wg & ~n.bv;

    // AXI4-Lite read
    if (c.rv && rready_in) begin
      n.rv = 1'b0;
    end
    if (arvalid_in && c.arr) begin
      n.rv = 1'b1;
      n.rd = 32'h0000_0000;
      n.rresp = `SSSP_RESP_OK;
      case (araddr_in)
        `SSSP_M_CTRL: begin
          n.rd[`SSSP_M_SEND] = c.send;
          n.rd[`SSSP_M_NINE] = c.nine;
        end
        `SSSP_M_STAT: begin
          n.rd[`SSSP_M_BUSY] = c.busy;
          n.rd[`SSSP_M_DONE] = c.done;
        end
        `SSSP_M_RXD: n.rd[8:0] = c.rx;
        `SSSP_M_DATA: n.rresp = `SSSP_RESP_OK;
        default: n.rresp = `SSSP_RESP_ERR;
      endcase
    end
    n.arr = ~n.rv;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      c <= '0;
    end else begin
      c <= n;
    end
  end

  assign link.shift_clock = c.ck;
  assign link.mst_data_out = c.dout;
  assign link.mst_data_oe = c.doe;
  assign awready_out = c.awr;
  assign wready_out = c.wr;
  assign bresp_out = c.bresp;
  assign bvalid_out = c.bv;
  assign arready_out = c.arr;
  assign rdata_out = c.rd;
  assign rresp_out = c.rresp;
  assign rvalid_out = c.rv;
endmodule : sssp_mst

// >>> tb/sssp_link_properties.sv
// Checker for the shift clock and data line between the two ends
module sssp_link_properties #(
  parameter logic [7:0] HALF_DIV = 8'h08
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic shift_clock,
  input wire logic serial_data,
  input wire logic dev_data_out,
  input wire logic dev_data_oe,
  input wire logic mst_data_out,
  input wire logic mst_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  // A low run longer than any low phase marks the end of a frame
  localparam logic [4:0] IDLE_RUN = 5'(HALF_DIV + 8'h02);
  logic [4:0] low_reg;
  logic [3:0] falls_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      low_reg <= 5'h00;
      falls_reg <= 4'h0;
    end else begin
      low_reg <= shift_clock ? 5'h00 : low_reg + {4'h0, ~&low_reg};
      if ($fell(shift_clock)) begin
        falls_reg <= falls_reg + 4'h1;
      end else if (low_reg == IDLE_RUN) begin
        falls_reg <= 4'h0;
      end
    end
  end

  chk_clk_high_span: assert property (
    $rose(shift_clock) |-> shift_clock [*8] ##1 !shift_clock)
    else $error("shift clock high phase is not eight cycles");
  chk_clk_low_span: assert property (
    $fell(shift_clock) |-> !shift_clock [*8])
    else $error("shift clock low phase shorter than eight cycles");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rstn_in |=> !shift_clock && !dev_data_oe && !mst_data_oe)
    else $error("link driven during reset");
  chk_line_release: assert property (
    !dev_data_oe && !mst_data_oe |-> serial_data)
    else $error("released data line not high");
  chk_dev_bit_settle: assert property (
    $rose(shift_clock) && dev_data_oe |=> $stable(dev_data_out) [*2])
    else $error("port bit changed too soon after rising edge");
  chk_dev_bit_hold: assert property (
    $fell(shift_clock) && dev_data_oe |->
      dev_data_out == $past(dev_data_out, 3))
    else $error("port bit not settled at falling edge");
  chk_mst_bit_hold: assert property (
    $fell(shift_clock) && mst_data_oe |->
      mst_data_out == $past(mst_data_out, 7))
    else $error("controller bit moved during high phase");
  chk_frame_bit_count: assert property (
    low_reg == IDLE_RUN && falls_reg != 4'h0 |->
      falls_reg == 4'h8 || falls_reg == 4'h9)
    else $error("frame length is neither eight nor nine bits");

  cover property ($rose(dev_data_oe));
  cover property ($rose(mst_data_oe));
  cover property (low_reg == IDLE_RUN && falls_reg == 4'h9);
endmodule : sssp_link_properties

// >>> tb/test_sync_serial_slave_port.sv
// Bench joining the controller and the serial port across the link
`include "sssp_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module test_sync_serial_slave_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, rwr, rrd, awv, wv, bry, arv, rry, wake, irq;
  logic awr, wr, bv, arr, rv;
  logic [2:0] ra;
  logic [7:0] rwd, rrdata, r;
  logic [3:0] awa, ara;
  logic [31:0] wd, rdat, g;
  logic [1:0] br, rr, resp;
  logic [8:0] words [2] = '{9'h1c3, 9'h024};
  int miscompares, checks;

  sssp_link_if link();
  sssp_dev sssp_dev_inst (.sys_clk_in(clk), .rstn_in(rstn), .link(link.dev),
    .reg_addr_in(ra), .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_wdata_in(rwd),
    .reg_rdata_out(rrdata), .wake_out(wake), .irq_out(irq));
  sssp_mst sssp_mst_inst (.sys_clk_in(clk), .rstn_in(rstn), .link(link.mst),
    .awaddr_in(awa), .awvalid_in(awv), .awready_out(awr), .wdata_in(wd),
    .wstrb_in(4'hf), .wvalid_in(wv), .wready_out(wr), .bresp_out(br),
    .bvalid_out(bv), .bready_in(bry), .araddr_in(ara), .arvalid_in(arv),
    .arready_out(arr), .rdata_out(rdat), .rresp_out(rr), .rvalid_out(rv),
    .rready_in(rry));
  sssp_link_properties sssp_link_properties_inst (.sys_clk_in(clk),
    .rstn_in(rstn), .shift_clock(link.shift_clock),
    .serial_data(link.serial_data), .dev_data_out(link.dev_data_out),
    .dev_data_oe(link.dev_data_oe), .mst_data_out(link.mst_data_out),
    .mst_data_oe(link.mst_data_oe));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic dwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : dwr

  // Read data stands until the next read, so one spare cycle is safe
  task automatic drd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    repeat (2) @(posedge clk);
    d = rrdata;
  endtask : drd

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    `CHK("write resp", `SSSP_RESP_OK, br)
    bry <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    rs = rr;
    rry <= 1'b0;
  endtask : axi_rd

  // One controller frame: set mode, send or collect a word, await idle
  task automatic frame(input logic [31:0] c, input logic [31:0] d,
                       output logic [31:0] got);
    logic [31:0] s;
    axi_wr(`SSSP_M_CTRL, c);
    axi_wr(`SSSP_M_DATA, d);
    do axi_rd(`SSSP_M_STAT, s, resp); while (s[`SSSP_M_BUSY]);
    `CHK("frame done", 1'b1, s[`SSSP_M_DONE])
    axi_rd(`SSSP_M_RXD, got, resp);
    `CHK("rx resp", `SSSP_RESP_OK, resp)
  endtask : frame

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    {rstn, rwr, rrd, awv, wv, bry, arv, rry} = 8'h00;
    {ra, rwd, awa, ara, wd} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    axi_rd(4'h1, g, resp);
    `CHK("unmapped resp", `SSSP_RESP_ERR, resp)
    dwr(`SSSP_A_RXCTL, 8'h80);
    dwr(`SSSP_A_TXCTL, 8'h30);
    dwr(`SSSP_A_TXHOLD, 8'ha5);
    dwr(`SSSP_A_TXHOLD, 8'h3c);
    dwr(`SSSP_A_INTCTL, 8'hc2);
    drd(`SSSP_A_INTCTL, r);
    `CHK("tx flag held", 1'b0, r[`SSSP_IC_TX_FLAG])
    `CHK("wake held", 1'b0, wake)
    frame(32'h0, 32'h0, g);
    `CHK("first word", 8'ha5, g[7:0])
    drd(`SSSP_A_INTCTL, r);
    `CHK("tx flag", 1'b1, r[`SSSP_IC_TX_FLAG])
    `CHK("tx wake irq", 2'b11, {wake, irq})
    frame(32'h0, 32'h0, g);
    `CHK("second word", 8'h3c, g[7:0])
    dwr(`SSSP_A_TXCTL, 8'h71);
    dwr(`SSSP_A_TXHOLD, 8'h96);
    frame(32'h2, 32'h0, g);
    `CHK("nine bit tx", 9'h196, g[8:0])
    // Clock source set: the port must stay off the line
    dwr(`SSSP_A_TXCTL, 8'hb0);
    dwr(`SSSP_A_TXHOLD, 8'h00);
    frame(32'h0, 32'h0, g);
    `CHK("port off", 8'hff, g[7:0])
    dwr(`SSSP_A_TXCTL, 8'h10);
    dwr(`SSSP_A_INTCTL, 8'h01);
    dwr(`SSSP_A_RXCTL, 8'hb0);
    frame(32'h1, 32'h5a, g);
    drd(`SSSP_A_INTCTL, r);
    `CHK("rx flag", 1'b1, r[`SSSP_IC_RX_FLAG])
    `CHK("rx wake irq", 2'b10, {wake, irq})
    drd(`SSSP_A_RXCTL, r);
    drd(`SSSP_A_RXDATA, r);
    `CHK("rx data", 8'h5a, r)
    drd(`SSSP_A_INTCTL, r);
    `CHK("rx flag read", 1'b0, r[`SSSP_IC_RX_FLAG])
    dwr(`SSSP_A_RXCTL, 8'hd0);
    for (int i = 0; i < 2; i++) begin
      frame(32'h3, {23'h0, words[i]}, g);
      drd(`SSSP_A_RXCTL, r);
      `CHK("rx ninth", words[i][8], r[`SSSP_RC_NINTH])
      drd(`SSSP_A_RXDATA, r);
      `CHK("rx nine data", words[i][7:0], r)
    end
    dwr(`SSSP_A_RXCTL, 8'h90);
    frame(32'h1, 32'h11, g);
    frame(32'h1, 32'h22, g);
    drd(`SSSP_A_RXCTL, r);
    `CHK("overrun", 1'b1, r[`SSSP_RC_OVERRUN])
    drd(`SSSP_A_RXDATA, r);
    `CHK("kept word", 8'h11, r)
    dwr(`SSSP_A_RXCTL, 8'h80);
    drd(`SSSP_A_RXCTL, r);
    `CHK("overrun clear", 1'b0, r[`SSSP_RC_OVERRUN])
    dwr(`SSSP_A_RXCTL, 8'h90);
    frame(32'h1, 32'h33, g);
    drd(`SSSP_A_RXDATA, r);
    `CHK("rx resumed", 8'h33, r)
    complete_run();
  end
endmodule : test_sync_serial_slave_port
